// ---- mhsl_params.svh ----
// Purpose: Offsets, bit positions, reset values of the modem handshake block
// Assumes: Byte addresses on a 32-bit APB, one register per aligned word
// Notes: Definitions only
`ifndef MHSL_PARAMS_SVH
`define MHSL_PARAMS_SVH

// ----------------------------------------
// Register offsets (low address byte)
// ----------------------------------------
`define MHSL_OFF_MSR 8'h00
`define MHSL_OFF_MCR 8'h04
`define MHSL_OFF_IST 8'h08
`define MHSL_OFF_IMSK 8'h0C

// ----------------------------------------
// Modem status bits
// ----------------------------------------
`define MHSL_MSR_DCTS 0
`define MHSL_MSR_DDSR 1
`define MHSL_MSR_DDCD 3
`define MHSL_MSR_CTS 4
`define MHSL_MSR_DSR 5
`define MHSL_MSR_DCD 7

// ----------------------------------------
// Line control bits
// ----------------------------------------
`define MHSL_MCR_DTR 0
`define MHSL_MCR_LOOP 4
`define MHSL_MCR_AUTO 5
`define MHSL_MCR_MASK 8'h31

// ----------------------------------------
// Event status / mask bits, line order
// ----------------------------------------
`define MHSL_EV_CTS 0
`define MHSL_EV_DSR 1
`define MHSL_EV_DCD 2
`define MHSL_NLINES 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MHSL_RST_MCR 8'h00
`define MHSL_RST_EV 3'h0
`define MHSL_RST_RDATA 32'h0000_0000

`endif

// ---- mhsl_pkg.sv ----
// Purpose: Types shared by the modem handshake block and its bench
// Assumes: Nothing beyond the params header
// Notes: Bundles travel as packed structs
package mhsl_pkg;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} mhsl_apb_req_t;

	// Modem handshake inputs, all active low
	typedef struct packed {
		logic dcd_n;
		logic dsr_n;
		logic cts_n;
	} mhsl_modem_t;

	// Decoded register select
	typedef enum logic [4:0] {
		MHSL_SEL_NONE = 5'b00001,
		MHSL_SEL_MSR = 5'b00010,
		MHSL_SEL_MCR = 5'b00100,
		MHSL_SEL_IST = 5'b01000,
		MHSL_SEL_IMSK = 5'b10000
	} mhsl_sel_t;

endpackage

// ---- mhsl_top.sv ----
// Purpose: Modem handshake and status lines with APB registers
// Assumes: Modem inputs synchronous to sys_clk; zero-wait APB slave
// Notes: Read data is staged in the setup cycle; pready is always high
`timescale 1ns/1ns
`include "mhsl_params.svh"

// Function
// RULE1 - CTS level bit4, change flag bit0
// RULE2 - CTS change interrupts only outside auto mode
// RULE3 - Auto mode: CTS permits or holds transmitter
// RULE4 - Eight-bit data pins, driven only during reads
// RULE5 - DCD change flag at bit3
// RULE6 - DCD change raises enabled interrupt
// RULE7 - Driver-off high except while CPU reads
// RULE8 - DSR level at bit5
// RULE9 - DSR change flag at bit1
// RULE10 - DSR change raises enabled interrupt
// RULE11 - DTR active low, set by control bit
// RULE12 - DTR inactive on reset and loop mode
// RULE13 - Status read clears all change flags; the code clears only the flags the staged read showed
module mhsl_top #(
	parameter int PIN_W = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire mhsl_pkg::mhsl_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Data pins toward the CPU side transceiver
	output logic [PIN_W-1:0] data_o,
	output logic data_oe,
	output logic bus_driver_off,
	// Modem lines
	input wire mhsl_pkg::mhsl_modem_t modem_in,
	output logic dtr_n,
	// Transmitter gate and interrupt
	output logic tx_permit,
	output logic irq
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	generate
		if (PIN_W != 8) begin : g_bad_width
			$error("PIN_W must be 8");
		end
	endgenerate

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic mhsl_pkg::mhsl_sel_t reg_sel(input logic [7:0] a);
		mhsl_pkg::mhsl_sel_t s;
		s = mhsl_pkg::MHSL_SEL_NONE;
		if (a == `MHSL_OFF_MSR) begin
			s = mhsl_pkg::MHSL_SEL_MSR;
		end else if (a == `MHSL_OFF_MCR) begin
			s = mhsl_pkg::MHSL_SEL_MCR;
		end else if (a == `MHSL_OFF_IST) begin
			s = mhsl_pkg::MHSL_SEL_IST;
		end else if (a == `MHSL_OFF_IMSK) begin
			s = mhsl_pkg::MHSL_SEL_IMSK;
		end
		return s;
	endfunction

	mhsl_pkg::mhsl_sel_t sel;
	logic setup_rd;
	logic acc;
	logic acc_rd;
	logic acc_wr;

	assign sel = reg_sel(apb_req.paddr);
	assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign acc = apb_req.psel && apb_req.penable;
	assign acc_rd = acc && !apb_req.pwrite;
	assign acc_wr = acc && apb_req.pwrite;

	// ----------------------------------------
	// Line sampling and change detection
	// ----------------------------------------
	logic [`MHSL_NLINES-1:0] line_act;
	logic [`MHSL_NLINES-1:0] lvl_r;
	logic [`MHSL_NLINES-1:0] chg;
	logic primed_r;

	assign line_act = ~{modem_in.dcd_n, modem_in.dsr_n, modem_in.cts_n};

	// First sample after reset only primes, so a low pin is no change
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			primed_r <= 1'b0;
		end else begin
			primed_r <= 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `MHSL_NLINES; gi++) begin : g_line
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					lvl_r[gi] <= 1'b0;
				end else begin
					lvl_r[gi] <= line_act[gi];
				end
			end
			assign chg[gi] = primed_r && (line_act[gi] != lvl_r[gi]);
		end
	endgenerate

	// ----------------------------------------
	// Modem status change flags
	// ----------------------------------------
	logic [`MHSL_NLINES-1:0] msr_flg_r;
	logic [`MHSL_NLINES-1:0] msr_clr;
	logic [31:0] rdata_r;
	logic msr_rd_done;

	assign msr_rd_done = acc_rd && (sel == mhsl_pkg::MHSL_SEL_MSR);
	// Clear only what the staged read showed; later changes survive
	assign msr_clr = msr_rd_done ? {rdata_r[`MHSL_MSR_DDCD], rdata_r[`MHSL_MSR_DDSR],
		rdata_r[`MHSL_MSR_DCTS]} : '0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			msr_flg_r <= `MHSL_RST_EV;
		end else begin
			msr_flg_r <= (msr_flg_r & ~msr_clr) | chg; // RULE1 RULE5 RULE9 RULE13
		end
	end

	// ----------------------------------------
	// Line control register
	// ----------------------------------------
	logic [7:0] mcr_r;
	logic auto_cts;
	logic loop_on;

	assign auto_cts = mcr_r[`MHSL_MCR_AUTO];
	assign loop_on = mcr_r[`MHSL_MCR_LOOP];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mcr_r <= `MHSL_RST_MCR;
		end else if (acc_wr && sel == mhsl_pkg::MHSL_SEL_MCR) begin
			mcr_r <= apb_req.pwdata[7:0] & `MHSL_MCR_MASK;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	logic [`MHSL_NLINES-1:0] ist_r;
	logic [`MHSL_NLINES-1:0] imsk_r;
	logic [`MHSL_NLINES-1:0] ev_set;
	logic [`MHSL_NLINES-1:0] ist_clr;

	// CTS moves are flow control in auto mode, not an event
	assign ev_set = chg & {2'b11, !auto_cts}; // RULE2 RULE6 RULE10
	assign ist_clr = (acc_wr && sel == mhsl_pkg::MHSL_SEL_IST) ?
		apb_req.pwdata[`MHSL_NLINES-1:0] : '0;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ist_r <= `MHSL_RST_EV;
		end else begin
			ist_r <= (ist_r & ~ist_clr) | ev_set;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			imsk_r <= `MHSL_RST_EV;
		end else if (acc_wr && sel == mhsl_pkg::MHSL_SEL_IMSK) begin
			imsk_r <= apb_req.pwdata[`MHSL_NLINES-1:0];
		end
	end

	assign irq = |(ist_r & imsk_r); // RULE2 RULE6 RULE10

	// ----------------------------------------
	// Read data staging
	// ----------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = `MHSL_RST_RDATA;
		unique case (sel)
			mhsl_pkg::MHSL_SEL_MSR: begin
				rd_mux[`MHSL_MSR_DCTS] = msr_flg_r[`MHSL_EV_CTS];
				rd_mux[`MHSL_MSR_DDSR] = msr_flg_r[`MHSL_EV_DSR];
				rd_mux[`MHSL_MSR_DDCD] = msr_flg_r[`MHSL_EV_DCD];
				rd_mux[`MHSL_MSR_CTS] = lvl_r[`MHSL_EV_CTS]; // RULE1
				rd_mux[`MHSL_MSR_DSR] = lvl_r[`MHSL_EV_DSR]; // RULE8
				rd_mux[`MHSL_MSR_DCD] = lvl_r[`MHSL_EV_DCD];
			end
			mhsl_pkg::MHSL_SEL_MCR: begin
				rd_mux[7:0] = mcr_r;
			end
			mhsl_pkg::MHSL_SEL_IST: begin
				rd_mux[`MHSL_NLINES-1:0] = ist_r;
			end
			mhsl_pkg::MHSL_SEL_IMSK: begin
				rd_mux[`MHSL_NLINES-1:0] = imsk_r;
			end
			mhsl_pkg::MHSL_SEL_NONE: begin
				rd_mux = `MHSL_RST_RDATA;
			end
		endcase
	end

	// Staged in setup so the access phase answers at once
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= `MHSL_RST_RDATA;
		end else if (setup_rd) begin
			rdata_r <= rd_mux;
		end
	end

	assign prdata = rdata_r;
	assign pready = 1'b1;
	assign pslverr = acc && (sel == mhsl_pkg::MHSL_SEL_NONE);

	// ----------------------------------------
	// Data pins and driver control
	// ----------------------------------------
	assign data_o = rdata_r[PIN_W-1:0];
	assign data_oe = acc_rd; // RULE4
	assign bus_driver_off = !acc_rd; // RULE7

	// ----------------------------------------
	// Terminal ready and transmit gate
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dtr_n <= 1'b1; // RULE12
		end else begin
			dtr_n <= !(mcr_r[`MHSL_MCR_DTR] && !loop_on); // RULE11 RULE12
		end
	end

	// Uses the sampled level so the gate and the status bit agree
	assign tx_permit = !auto_cts || lvl_r[`MHSL_EV_CTS]; // RULE3

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	cts_flag_set_a: assert property ( // RULE1
		chg[`MHSL_EV_CTS] |=> msr_flg_r[`MHSL_EV_CTS]
	) else $error("CTS change flag not set");

	dcd_flag_set_a: assert property ( // RULE5
		chg[`MHSL_EV_DCD] |=> msr_flg_r[`MHSL_EV_DCD]
	) else $error("DCD change flag not set");

	dsr_level_a: assert property ( // RULE8
		setup_rd && sel == mhsl_pkg::MHSL_SEL_MSR
		|=> rdata_r[`MHSL_MSR_DSR] == $past(lvl_r[`MHSL_EV_DSR])
	) else $error("DSR level bit wrong");

	dsr_flag_set_a: assert property ( // RULE9
		chg[`MHSL_EV_DSR] |=> msr_flg_r[`MHSL_EV_DSR]
	) else $error("DSR change flag not set");

	msr_read_clear_a: assert property ( // RULE13
		msr_rd_done && chg == '0 |=> (msr_flg_r & $past(msr_clr)) == '0
	) else $error("Status read left a flag");

	cts_auto_quiet_a: assert property ( // RULE2
		auto_cts && $stable(auto_cts) |=> !$rose(ist_r[`MHSL_EV_CTS])
	) else $error("CTS event in auto mode");

	dcd_irq_raise_a: assert property ( // RULE6
		chg[`MHSL_EV_DCD] && imsk_r[`MHSL_EV_DCD] && $stable(imsk_r) ##1
		$stable(imsk_r) |-> irq
	) else $error("DCD change gave no interrupt");

	dsr_irq_raise_a: assert property ( // RULE10
		chg[`MHSL_EV_DSR] && imsk_r[`MHSL_EV_DSR] |=> ##[0:1] irq || !imsk_r[`MHSL_EV_DSR]
	) else $error("DSR change gave no interrupt");

	tx_hold_a: assert property ( // RULE3
		auto_cts && !lvl_r[`MHSL_EV_CTS] |-> !tx_permit
	) else $error("Transmit not held off");

	bus_drive_a: assert property ( // RULE4
		data_oe |-> apb_req.psel && apb_req.penable && !apb_req.pwrite
			&& data_o == rdata_r[PIN_W-1:0]
	) else $error("Data pins driven outside a read");

	driver_off_a: assert property ( // RULE7
		bus_driver_off != data_oe
	) else $error("Driver-off not opposite of drive");

	dtr_active_a: assert property ( // RULE11
		mcr_r[`MHSL_MCR_DTR] && !loop_on ##1 mcr_r[`MHSL_MCR_DTR] && !loop_on |-> !dtr_n
	) else $error("DTR not active");

	dtr_loop_off_a: assert property ( // RULE12
		loop_on |=> dtr_n
	) else $error("DTR active in loop mode");

	cts_level_a: assert property ( // RULE1
		setup_rd && sel == mhsl_pkg::MHSL_SEL_MSR
		|=> rdata_r[`MHSL_MSR_CTS] == $past(lvl_r[`MHSL_EV_CTS])
	) else $error("CTS level bit wrong");

	cts_event_a: assert property ( // RULE2
		chg[`MHSL_EV_CTS] && !auto_cts |=> ist_r[`MHSL_EV_CTS]
	) else $error("CTS change gave no event");

	dcd_event_a: assert property ( // RULE6
		chg[`MHSL_EV_DCD] |=> ist_r[`MHSL_EV_DCD]
	) else $error("DCD change gave no event");

	dsr_event_a: assert property ( // RULE10
		chg[`MHSL_EV_DSR] |=> ist_r[`MHSL_EV_DSR]
	) else $error("DSR change gave no event");

	tx_permit_a: assert property ( // RULE3
		!auto_cts || lvl_r[`MHSL_EV_CTS] |-> tx_permit
	) else $error("Transmit held without cause");

	rdata_hold_a: assert property ( // RULE4
		!setup_rd |=> $stable(rdata_r)
	) else $error("Data pins moved outside a read");

	dtr_clear_a: assert property ( // RULE11
		!mcr_r[`MHSL_MCR_DTR] |=> dtr_n
	) else $error("DTR active with its bit cleared");

	flag_hold_a: assert property ( // RULE13
		!msr_rd_done |=> msr_flg_r == $past(msr_flg_r | chg)
	) else $error("Change flag lost without a read");

endmodule

// ---- mhsl_modem_model.sv ----
// Purpose: Modem side model driving the handshake lines
// Assumes: Lines change just after a clock edge
// Notes: Slow mode lands each change up to three edges late
`timescale 1ns/1ns
module mhsl_modem_model (
	// Clock
	input wire logic sys_clk,
	// Bench control
	input wire logic [2:0] lvl_req,
	input wire logic slow,
	// Lines toward the device
	output mhsl_pkg::mhsl_modem_t modem_in
);
	// Lines idle high, so no pin reads active before the bench moves one
	logic [2:0] line_r = 3'h7;
	logic [1:0] wait_r = 2'h0;
	assign modem_in = line_r;
	// A real modem may answer late, so the device must not assume a delay
	always @(posedge sys_clk) begin
		if (!slow || wait_r == 2'h2) begin
			line_r <= lvl_req;
			wait_r <= 2'h0;
		end else begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// ---- mhsl_top_tb.sv ----
// Purpose: Self-checking bench of the modem handshake block
// Assumes: Zero-wait APB slave, modem model on the lines
// Notes: Reads note expected data in a queue; a monitor compares
`timescale 1ns/1ns
`include "mhsl_params.svh"
module mhsl_top_tb;
	logic sys_clk, rst_n, slow;
	mhsl_pkg::mhsl_apb_req_t apb_req;
	mhsl_pkg::mhsl_modem_t modem_in;
	logic [31:0] prdata;
	logic pready, pslverr, data_oe, bus_driver_off, dtr_n, tx_permit, irq;
	logic [7:0] data_o;
	logic [2:0] lvl, prev, m;
	logic [32:0] e;
	logic [32:0] expq[$];
	logic [7:0] mcr_v[4] = '{8'h01, 8'h11, 8'h31, 8'h00};
	int err_count, n_compared;

	mhsl_top i_mhsl_top (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .data_o(data_o),
		.data_oe(data_oe), .bus_driver_off(bus_driver_off), .modem_in(modem_in),
		.dtr_n(dtr_n), .tx_permit(tx_permit), .irq(irq));
	mhsl_modem_model i_mhsl_modem_model (.sys_clk(sys_clk), .lvl_req(lvl), .slow(slow),
		.modem_in(modem_in));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// APB master
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		apb_req <= '0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		expq.push_back(x);
		xfer(1'b0, a, 32'h0000_0000);
	endtask

	// Levels read active high; flags show which lines moved
	function automatic logic [32:0] msr(input logic [2:0] p, input logic [2:0] c);
		logic [2:0] ch;
		ch = p ^ c;
		return {25'h0, ~c[2], 1'b0, ~c[1], ~c[0], ch[2], 1'b0, ch[1], ch[0]};
	endfunction

	// Sees pre-edge values, so it never races the bench drivers
	always @(posedge sys_clk) begin
		if (apb_req.psel && apb_req.penable && !apb_req.pwrite && pready === 1'b1
			&& expq.size() != 0) begin
			e = expq.pop_front();
			cmp("prdata", e, {pslverr, prdata});
			cmp("data_o", {25'h0, e[7:0]}, {25'h0, data_o});
			cmp("drive", 33'h0_0000_0002, {31'h0, data_oe, bus_driver_off});
		end else if (rst_n) begin
			cmp("drive", 33'h0_0000_0001, {31'h0, data_oe, bus_driver_off});
		end
	end

	initial begin
		#80000;
		err_count++;
		conclude();
	end

	initial begin
		rst_n = 1'b0;
		apb_req = '0;
		lvl = 3'h7;
		slow = 1'b0;
		err_count = 0;
		n_compared = 0;
		void'($urandom(93));
		wt(12);
		rst_n <= 1'b1;
		wt(2);
		cmp("reset pins", 33'h0_0000_0006, {30'h0, dtr_n, tx_permit, irq});
		rd(`MHSL_OFF_MCR, 33'h0_0000_0000);
		rd(`MHSL_OFF_MSR, msr(3'h7, 3'h7));
		for (int i = 0; i < 12; i++) begin
			m = 3'($urandom);
			xfer(1'b1, `MHSL_OFF_IMSK, {29'h0, m});
			prev = lvl;
			lvl <= 3'($urandom);
			slow <= i[0];
			wt(8);
			cmp("irq", {32'h0, |((prev ^ lvl) & m)}, {32'h0, irq});
			rd(`MHSL_OFF_IMSK, {30'h0, m});
			rd(`MHSL_OFF_IST, {30'h0, prev ^ lvl});
			rd(`MHSL_OFF_MSR, msr(prev, lvl));
			rd(`MHSL_OFF_MSR, msr(lvl, lvl));
			xfer(1'b1, `MHSL_OFF_IST, 32'h0000_0007);
		end
		// Auto mode: the line gates the transmitter and raises no event
		xfer(1'b1, `MHSL_OFF_IMSK, 32'h0000_0007);
		xfer(1'b1, `MHSL_OFF_MCR, 32'h0000_0020);
		for (int i = 0; i < 2; i++) begin
			prev = lvl;
			lvl <= lvl ^ 3'h1;
			wt(8);
			cmp("auto", {31'h0, ~lvl[0], 1'b0}, {31'h0, tx_permit, irq});
			rd(`MHSL_OFF_IST, 33'h0_0000_0000);
			rd(`MHSL_OFF_MSR, msr(prev, lvl));
		end
		foreach (mcr_v[i]) begin
			xfer(1'b1, `MHSL_OFF_MCR, {24'h0, mcr_v[i]});
			wt(2);
			cmp("dtr_n", {32'h0, ~(mcr_v[i][0] & ~mcr_v[i][4])}, {32'h0, dtr_n});
			rd(`MHSL_OFF_MCR, {25'h0, mcr_v[i] & 8'h31});
		end
		xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
		rd(8'h10, {1'b1, 32'h0000_0000});
		rd(`MHSL_OFF_IMSK, 33'h0_0000_0007);
		// Mid-run reset with the terminal line active must drop it at once
		xfer(1'b1, `MHSL_OFF_MCR, 32'h0000_0001);
		wt(2);
		cmp("dtr_n on", 33'h0_0000_0000, {32'h0, dtr_n});
		rst_n <= 1'b0;
		wt(2);
		cmp("reset pins", 33'h0_0000_0006, {30'h0, dtr_n, tx_permit, irq});
		rst_n <= 1'b1;
		wt(2);
		rd(`MHSL_OFF_MCR, 33'h0_0000_0000);
		rd(`MHSL_OFF_MSR, msr(lvl, lvl));
		wt(4);
		conclude();
	end
endmodule
